// ==== rtl/port_pin_function_control.sv ====
// Register set and pin control for ports 0, 1, 3, 4 and 5.
// Assumes access strobes and control inputs come from the clk domain;
// only the pins themselves are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_params.svh"
module port_pin_function_control (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire port_ctrl_pkg::port_e acc_port,
	input wire port_ctrl_pkg::kind_e acc_kind,
	input wire logic acc_high,
	input wire logic [15:0] acc_mask,
	input wire logic [15:0] acc_wdata,
	output logic [15:0] acc_rdata,
	input wire logic [`NPORT-1:0][15:0] pin_in,
	output logic [`NPORT-1:0][15:0] pin_out,
	output logic [`NPORT-1:0][15:0] pin_oe,
	input wire logic [`NPORT-1:0][15:0] alt_out,
	input wire logic [`NPORT-1:0][15:0] alt_oe,
	output logic [`NPORT-1:0][15:0] alt_in,
	output logic [`NPORT-1:0][15:0] mode_sel,
	output logic [`NPORT-1:0][15:0] func_sel,
	input wire logic [`ANALOG_W-1:0] analog_en,
	input wire logic dac_busy,
	input wire logic intp_rise_en,
	input wire logic intp_fall_en,
	input wire logic uart_rx_en,
	input wire logic [`KEY_SHARE_W-1:0] key_mode,
	input wire logic [`KEY_SHARE_W-1:0] timer_edge_en,
	output logic uart_share_fault,
	output logic [`KEY_SHARE_W-1:0] key_share_fault,
	output logic analog_dir_fault,
	output logic dac_access_fault
);
	import port_ctrl_pkg::*;

	localparam logic [15:0] IMPL [0:`NPORT-1] = '{
		`PORT0_IMPL, `PORT1_IMPL, `PORT3_IMPL, `PORT4_IMPL, `PORT5_IMPL
	};

	// Direction resets to all inputs, so it takes the implemented mask
	localparam word_t RST_VAL [0:`NKIND-1] = '{
		`DATA_RST, 16'h0000, `MODE_RST, `FUNC_RST, `OD_RST
	};

	// Register array indexed by kind then port
	word_t regs_reg [0:`NKIND-1][0:`NPORT-1];
	word_t rdata_reg;
	logic uart_fault_reg;
	logic [`KEY_SHARE_W-1:0] key_fault_reg;
	logic analog_fault_reg;
	logic dac_fault_reg;
	word_t view [0:`NPORT-1];

	// Alias writes shift the low byte up to bits 8 to 15
	wire word_t wr_mask_eff = acc_high ? {acc_mask[7:0], 8'h00}
		: acc_mask;
	wire word_t wr_data_eff = acc_high ? {acc_wdata[7:0], 8'h00}
		: acc_wdata;
	wire is_mode3 = (acc_kind == KIND_MODE) && (acc_port == PORT3);
	// Reserved mode bits of port 3 are held at zero whatever is written
	wire word_t wmask = IMPL[acc_port]
		& (is_mode3 ? `MODE3_WMASK : 16'hFFFF);
	wire word_t cur_val = regs_reg[acc_kind][acc_port];
	wire [7:0] cur_low = cur_val[7:0];
	// Bits outside the alias mask keep their value
	wire word_t wr_val = (cur_val & ~wr_mask_eff)
		| (wr_data_eff & wr_mask_eff & wmask);
	wire wr_hit = ce && acc_wr;
	wire rd_hit = ce && acc_rd;
	wire word_t rd_val = (acc_kind == KIND_DATA) ? view[acc_port] : cur_val;
	wire word_t rd_shift = acc_high ? {8'h00, rd_val[15:8]}
		: rd_val;
	wire [7:0] rd_hi = rd_val[15:8];
	wire port1_data_acc = (acc_wr || acc_rd) && (acc_port == PORT1)
		&& (acc_kind == KIND_DATA);
	wire word_t port1_dir = regs_reg[KIND_DIR][PORT1];
	wire word_t port3_mode = regs_reg[KIND_MODE][PORT3];
	wire word_t port5_mode = regs_reg[KIND_MODE][PORT5];
	// Analog outputs are never driven digitally
	wire word_t analog_word = {{(16 - `ANALOG_W){1'b0}}, analog_en};
	wire uart_fault_next = port3_mode[`UART_SHARE_BIT] && uart_rx_en
		&& (intp_rise_en || intp_fall_en);
	wire [`KEY_SHARE_W-1:0] key_fault_next =
		port5_mode[`KEY_SHARE_W-1:0] & key_mode & timer_edge_en;
	wire analog_fault_next =
		|(analog_en & ~port1_dir[`ANALOG_W-1:0]);
	wire dac_fault_next = port1_data_acc && dac_busy;

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int k = 0; k < `NKIND; k++) begin
				for (int p = 0; p < `NPORT; p++) begin
					regs_reg[k][p] <= (k == int'(KIND_DIR)) ? IMPL[p]
						: RST_VAL[k];
				end
			end
		end else if (wr_hit) begin
			regs_reg[acc_kind][acc_port] <= wr_val;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 16'h0000;
		end else if (rd_hit) begin
			rdata_reg <= rd_shift;
		end
	end

	// Sharing faults are flags only; the pin setup is left as written
	always_ff @(posedge clk) begin
		if (srst) begin
			uart_fault_reg <= 1'b0;
			key_fault_reg <= '0;
			analog_fault_reg <= 1'b0;
			dac_fault_reg <= 1'b0;
		end else if (ce) begin
			uart_fault_reg <= uart_fault_next;
			key_fault_reg <= key_fault_next;
			analog_fault_reg <= analog_fault_next;
			dac_fault_reg <= dac_fault_next;
		end
	end

	assign acc_rdata = rdata_reg;
	assign uart_share_fault = uart_fault_reg;
	assign key_share_fault = key_fault_reg;
	assign analog_dir_fault = analog_fault_reg;
	assign dac_access_fault = dac_fault_reg;

	for (genvar p = 0; p < `NPORT; p++) begin : g_port
		wire word_t dir_eff = (p == 1) ? (regs_reg[KIND_DIR][p] | analog_word)
			: regs_reg[KIND_DIR][p];
		// Analog pins stay undriven even if alternate mode is chosen
		wire word_t mode_eff = (p == 1)
			? (regs_reg[KIND_MODE][p] & ~analog_word)
			: regs_reg[KIND_MODE][p];
		pin_bank #(
			.WIDTH(16),
			.IMPL(IMPL[p])
		) u_bank (
			.clk(clk),
			.srst(srst),
			.ce(ce),
			.data(regs_reg[KIND_DATA][p]),
			.dir(dir_eff),
			.mode(mode_eff),
			.od(regs_reg[KIND_OD][p]),
			.alt_out(alt_out[p]),
			.alt_oe(alt_oe[p]),
			.pin_in(pin_in[p]),
			.pin_out(pin_out[p]),
			.pin_oe(pin_oe[p]),
			.pin_sync(alt_in[p]),
			.view(view[p])
		);
		assign mode_sel[p] = regs_reg[KIND_MODE][p];
		assign func_sel[p] = regs_reg[KIND_FUNC][p];
	end

	sequence alias_wr_s(kind_e k);
		ce && acc_wr && acc_high && acc_kind == k;
	endsequence

	property alias_write_p(kind_e k);
		@(posedge clk) disable iff (srst)
		alias_wr_s(k) |=>
			((regs_reg[k][$past(acc_port)] ^ $past(wr_data_eff))
			& $past(wr_mask_eff) & $past(wmask)) == 16'h0000;
	endproperty

	data_alias_a: assert property (alias_write_p(KIND_DATA))
		else $error("data alias write lost");
	dir_alias_a: assert property (alias_write_p(KIND_DIR))
		else $error("direction alias write lost");
	mode_alias_a: assert property (alias_write_p(KIND_MODE))
		else $error("mode alias write lost");
	func_alias_a: assert property (alias_write_p(KIND_FUNC))
		else $error("function alias write lost");
	od_alias_a: assert property (alias_write_p(KIND_OD))
		else $error("open-drain alias write lost");

	sequence alias_any_wr_s;
		ce && acc_wr && acc_high;
	endsequence

	low_byte_kept_a: assert property (
		@(posedge clk) disable iff (srst)
		alias_any_wr_s |=>
			regs_reg[$past(acc_kind)][$past(acc_port)][7:0] == $past(cur_low))
		else $error("alias write touched low byte");

	alias_read_a: assert property (
		@(posedge clk) disable iff (srst)
		(ce && acc_rd && acc_high) |=>
			acc_rdata == {8'h00, $past(rd_hi)})
		else $error("alias read not shifted down");

	mode3_reserved_a: assert property (
		@(posedge clk) disable iff (srst)
		(regs_reg[KIND_MODE][PORT3] & ~`MODE3_WMASK) == 16'h0000)
		else $error("reserved mode bits set");

	sequence word_wr_s;
		ce && acc_wr && !acc_high;
	endsequence

	word_write_a: assert property (
		@(posedge clk) disable iff (srst)
		word_wr_s |=>
			((regs_reg[$past(acc_kind)][$past(acc_port)]
			^ $past(acc_wdata)) & $past(acc_mask) & $past(wmask))
			== 16'h0000)
		else $error("word write lost");

	ce_hold_a: assert property (
		@(posedge clk) disable iff (srst)
		!ce |=> $stable(acc_rdata) && $stable(pin_oe)
			&& $stable(uart_share_fault) && $stable(key_share_fault))
		else $error("state moved with clock enable low");

	analog_undriven_a: assert property (
		@(posedge clk) disable iff (srst)
		ce |=> (pin_oe[1][`ANALOG_W-1:0] & $past(analog_en)) == '0)
		else $error("analog pin driven");

	dac_flag_a: assert property (
		@(posedge clk) disable iff (srst)
		(ce && port1_data_acc && dac_busy) |=> dac_access_fault)
		else $error("data access during conversion not flagged");

	uart_flag_a: assert property (
		@(posedge clk) disable iff (srst)
		(ce && port3_mode[`UART_SHARE_BIT] && uart_rx_en
			&& (intp_rise_en || intp_fall_en)) |=> uart_share_fault)
		else $error("shared receive pin conflict not flagged");
endmodule
`default_nettype wire

// ==== rtl/port_ctrl_params.svh ====
// Constants for the general-purpose port control block.
// Assumes inclusion by bare name from rtl/ before any module that uses it.
// Function
// - The port-3 data register shows its bits 8 to 15 as bits 0 to 7 of a high-byte alias for byte and bit access.
// - The port-3 direction register shows its bits 8 to 15 as bits 0 to 7 of a high-byte alias.
// - The port-3 mode-control register shows its bits 8 to 15 as bits 0 to 7 of a high-byte alias.
// - The port-3 function-control register shows its bits 8 to 15 as bits 0 to 7 of a high-byte alias.
// - The port-3 open-drain select register shows its bits 8 to 15 as bits 0 to 7 of a high-byte alias.
// - An open-drain bit acts only in port mode with direction 0 (output) and is ignored with direction 1 (input).
`ifndef PORT_CTRL_PARAMS_SVH
`define PORT_CTRL_PARAMS_SVH
`define NPORT 5
`define NKIND 5
`define WORD_W 16
`define PORT0_IMPL 16'h00FF
`define PORT1_IMPL 16'h0003
`define PORT3_IMPL 16'h03FF
`define PORT4_IMPL 16'h0007
`define PORT5_IMPL 16'h003F
`define MODE3_WMASK 16'h033F
`define DATA_RST 16'h0000
`define MODE_RST 16'h0000
`define FUNC_RST 16'h0000
`define OD_RST 16'h0000
`define UART_SHARE_BIT 1
`define KEY_SHARE_W 6
`define ANALOG_W 2
`endif

// ==== rtl/port_ctrl_pkg.sv ====
// Types shared by the port control block.
// Assumes nothing beyond a SystemVerilog compiler.
package port_ctrl_pkg;
	typedef enum logic [2:0] {
		PORT0 = 3'h0,
		PORT1 = 3'h1,
		PORT3 = 3'h2,
		PORT4 = 3'h3,
		PORT5 = 3'h4
	} port_e;
	typedef enum logic [2:0] {
		KIND_DATA = 3'h0,
		KIND_DIR = 3'h1,
		KIND_MODE = 3'h2,
		KIND_FUNC = 3'h3,
		KIND_OD = 3'h4
	} kind_e;
	typedef logic [15:0] word_t;
endpackage

// ==== rtl/pin_bank.sv ====
// One port's pin drivers and input synchronisers.
// Assumes pin_in is asynchronous; other inputs come from the clk domain.
`timescale 1ns/1ps
`default_nettype none
module pin_bank #(
	parameter int WIDTH = 16,
	parameter logic [15:0] IMPL = 16'hFFFF
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] data,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] mode,
	input wire logic [WIDTH-1:0] od,
	input wire logic [WIDTH-1:0] alt_out,
	input wire logic [WIDTH-1:0] alt_oe,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] pin_sync,
	output logic [WIDTH-1:0] view
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] oe_reg;
	wire [WIDTH-1:0] impl = IMPL[WIDTH-1:0];
	wire [WIDTH-1:0] in_sel = ~mode & dir;
	wire [WIDTH-1:0] od_low = ~mode & ~dir & od & ~data;
	// Open-drain only releases high bits; direction 1 masks it out
	wire [WIDTH-1:0] port_oe = ~mode & ~dir & (~od | ~data);
	wire [WIDTH-1:0] port_out = ~mode & data & ~od;
	wire [WIDTH-1:0] oe_next = ((mode & alt_oe) | port_oe) & impl;
	wire [WIDTH-1:0] out_next = ((mode & alt_out) | port_out) & impl;

	if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
		$error("pin_bank WIDTH must be 1 to 16");
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			sync_reg <= '0;
			out_reg <= '0;
			oe_reg <= '0;
		end else if (ce) begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign pin_sync = sync_reg & impl;
	// Input bits read the pin, output bits read the latch
	assign view = ((dir & sync_reg) | (~dir & data)) & impl;

	input_ignores_od_a: assert property (
		@(posedge clk) disable iff (srst)
		ce |=> ((pin_oe & $past(in_sel)) == '0))
		else $error("input pin driven in port mode");
	od_drives_low_a: assert property (
		@(posedge clk) disable iff (srst)
		ce |=> ((~pin_oe & $past(od_low)) == '0)
			&& ((pin_out & $past(od_low)) == '0))
		else $error("open-drain low not driven");
endmodule
`default_nettype wire

// ==== test/pin_world.sv ====
// Board seen by the port pins: pull-ups on some lines, external drivers.
// Assumes pin index 0..4 maps to ports 0, 1, 3, 4, 5.
`timescale 1ns/1ps
`default_nettype none
module pin_world #(
	parameter logic [15:0] PULL_UP = 16'h0001
) (
	input wire logic [4:0][15:0] pin_out,
	input wire logic [4:0][15:0] pin_oe,
	input wire logic [4:0][15:0] ext_en,
	input wire logic [4:0][15:0] ext_val,
	output logic [4:0][15:0] pin_level
);
	// Pulled-up lines rise when released; a floating line shows
	// the inverse of its latch so a stale read cannot pass
	always_comb begin
		for (int p = 0; p < 5; p++) begin
			for (int b = 0; b < 16; b++) begin
				pin_level[p][b] = pin_oe[p][b] ? pin_out[p][b]
					: ext_en[p][b] ? ext_val[p][b]
					: PULL_UP[b] ? 1'h1 : ~pin_out[p][b];
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/port_pin_function_control_tb_top.sv ====
// Self-checking bench for the port control block.
// Assumes the design files and pin_world are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	mismatches++; $display("Error %s exp %h got %h", nm, e, g); end end
module port_pin_function_control_tb_top;
	import port_ctrl_pkg::*;
	logic clk = 1'h0, srst = 1'h1, ce = 1'h1, acc_wr = 1'h0, acc_rd = 1'h0;
	logic acc_high = 1'h0, dac_busy = 1'h0, uart_rx_en = 1'h0;
	logic intp_rise_en = 1'h0, intp_fall_en = 1'h0;
	port_e acc_port = PORT0;
	kind_e acc_kind = KIND_DATA;
	logic [15:0] acc_mask = 16'h0, acc_wdata = 16'h0, acc_rdata, m, e, d;
	logic [4:0][15:0] pin_in, pin_out, pin_oe, alt_in, mode_sel, func_sel;
	logic [4:0][15:0] alt_out = 80'h0, alt_oe = 80'h0;
	logic [4:0][15:0] ext_en = 80'h0, ext_val = 80'h0;
	logic [1:0] analog_en = 2'h0;
	logic [5:0] key_mode = 6'h0, timer_edge_en = 6'h0, key_share_fault;
	logic uart_share_fault, analog_dir_fault, dac_access_fault;
	int mismatches = 0, num_checks = 0;
	kind_e kinds[5] = '{KIND_DIR, KIND_DATA, KIND_MODE, KIND_FUNC, KIND_OD};
	port_e odp[4] = '{PORT0, PORT3, PORT4, PORT5};

	port_pin_function_control dut (.clk(clk), .srst(srst), .ce(ce),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_port(acc_port),
		.acc_kind(acc_kind), .acc_high(acc_high), .acc_mask(acc_mask),
		.acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out),
		.alt_oe(alt_oe), .alt_in(alt_in), .mode_sel(mode_sel),
		.func_sel(func_sel), .analog_en(analog_en), .dac_busy(dac_busy),
		.intp_rise_en(intp_rise_en), .intp_fall_en(intp_fall_en),
		.uart_rx_en(uart_rx_en), .key_mode(key_mode),
		.timer_edge_en(timer_edge_en), .uart_share_fault(uart_share_fault),
		.key_share_fault(key_share_fault),
		.analog_dir_fault(analog_dir_fault),
		.dac_access_fault(dac_access_fault));
	pin_world board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pin_level(pin_in));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic summarize;
		$display("Checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic acc(input logic wr, input port_e p, input kind_e k,
			input logic hi, input logic [15:0] mk, input logic [15:0] d);
		@(negedge clk);
		acc_wr = wr;
		acc_rd = !wr;
		acc_high = hi;
		acc_port = p;
		acc_kind = k;
		acc_mask = mk;
		acc_wdata = d;
		@(negedge clk);
		acc_wr = 1'h0;
		acc_rd = 1'h0;
	endtask

	task automatic wr(input port_e p, input kind_e k, input logic hi,
			input logic [15:0] mk, input logic [15:0] d);
		acc(1'h1, p, k, hi, mk, d);
	endtask

	task automatic rd_chk(input string nm, input port_e p, input kind_e k,
			input logic hi, input logic [15:0] ex);
		acc(1'h0, p, k, hi, 16'h0, 16'h0);
		`CHK(nm, ex, acc_rdata)
	endtask

	task automatic settle;
		repeat (2) @(negedge clk);
	endtask

	initial begin
		repeat (3) @(negedge clk);
		srst = 1'h0;
		rd_chk("dir3 rst", PORT3, KIND_DIR, 1'h0, 16'h03FF);
		`CHK("oe rst", 80'h0, pin_oe)
		foreach (kinds[i]) begin
			m = (kinds[i] == KIND_MODE) ? 16'h033F : 16'h03FF;
			e = 16'h0215 & m;
			// Mode alias data sets bit 9 only, so no reserved bit is written
			d = (kinds[i] == KIND_MODE) ? 16'h0002 : 16'h00FE;
			wr(PORT3, kinds[i], 1'h0, 16'hFFFF, 16'h0015);
			wr(PORT3, kinds[i], 1'h1, 16'h00FF, d);
			rd_chk("word", PORT3, kinds[i], 1'h0, e);
			rd_chk("alias", PORT3, kinds[i], 1'h1, {8'h0, e[15:8]});
			if (kinds[i] == KIND_FUNC)
				`CHK("func sel", e, func_sel[2])
			// Pin 0 stays an input so its pull-up never meets a drive
			wr(PORT3, kinds[i], 1'h0, 16'hFFFF,
				(kinds[i] == KIND_DIR) ? 16'h0001 : 16'h0000);
		end
		foreach (odp[i]) begin
			wr(odp[i], KIND_OD, 1'h0, 16'hFFFF, 16'h0001);
			wr(odp[i], KIND_DIR, 1'h0, 16'hFFFF, 16'h0000);
			wr(odp[i], KIND_DATA, 1'h0, 16'hFFFF, 16'h0000);
			settle;
			`CHK("od low", 4'hC, {pin_oe[odp[i]][1:0], pin_out[odp[i]][1:0]})
			wr(odp[i], KIND_DATA, 1'h0, 16'hFFFF, 16'h0003);
			settle;
			`CHK("od high", 4'hB, {pin_oe[odp[i]][1:0], pin_out[odp[i]][1], pin_in[odp[i]][0]})
			wr(odp[i], KIND_DIR, 1'h0, 16'hFFFF, 16'h0001);
			settle;
			`CHK("od input", 2'h2, pin_oe[odp[i]][1:0])
			wr(odp[i], KIND_DIR, 1'h0, 16'hFFFF, 16'hFFFF);
			wr(odp[i], KIND_OD, 1'h0, 16'hFFFF, 16'h0000);
		end
		ext_en[3] = 16'h0007;
		ext_val[3] = 16'h0005;
		settle;
		rd_chk("p4 pins", PORT4, KIND_DATA, 1'h0, 16'h0005);
		`CHK("alt in", 16'h0005, alt_in[3])
		wr(PORT3, KIND_MODE, 1'h0, 16'hFFFF, 16'h0102);
		uart_rx_en = 1'h1;
		intp_fall_en = 1'h1;
		alt_oe[2] = 16'h0100;
		alt_out[2] = 16'h0100;
		settle;
		`CHK("uart share", 1'h1, uart_share_fault)
		`CHK("mode sel", 16'h0102, mode_sel[2])
		`CHK("alt drive", 2'h3, {pin_oe[2][8], pin_out[2][8]})
		intp_fall_en = 1'h0;
		settle;
		`CHK("uart ok", 1'h0, uart_share_fault)
		wr(PORT5, KIND_MODE, 1'h0, 16'hFFFF, 16'h003F);
		key_mode = 6'h2A;
		timer_edge_en = 6'h0F;
		settle;
		`CHK("key share", 6'h0A, key_share_fault)
		analog_en = 2'h1;
		wr(PORT1, KIND_DIR, 1'h0, 16'hFFFF, 16'h0002);
		settle;
		`CHK("analog", 2'h2, {analog_dir_fault, pin_oe[1][0]})
		wr(PORT1, KIND_DIR, 1'h0, 16'hFFFF, 16'h0003);
		dac_busy = 1'h1;
		acc(1'h0, PORT1, KIND_DATA, 1'h0, 16'h0, 16'h0);
		`CHK("dac access", 2'h2, {dac_access_fault, analog_dir_fault})
		// Reset in mid-run must bring every pin back to input
		srst = 1'h1;
		@(negedge clk);
		srst = 1'h0;
		`CHK("oe rst2", 80'h0, pin_oe)
		rd_chk("dir3 rst2", PORT3, KIND_DIR, 1'h1, 16'h0003);
		ce = 1'h0;
		wr(PORT0, KIND_FUNC, 1'h0, 16'hFFFF, 16'h00AA);
		ce = 1'h1;
		rd_chk("ce hold", PORT0, KIND_FUNC, 1'h0, 16'h0000);
		`CHK("func hold", 16'h0000, func_sel[0])
		summarize();
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		#2000000;
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
